// ---- bench/smsc_core_model.sv ----
/* core stand-in: stop pulse on request, port latches that move each cycle.
   assumes go_i is a one-cycle request from the bench. */
`timescale 1ns/1ps
module smsc_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  output logic stop_instr_o,
  output logic [7:0] port_latch_o
);
  // peripherals taken as quiesced before go_i and restarted after wake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_instr_o <= 1'b0;
      port_latch_o <= 8'hA5;
    end else begin
      stop_instr_o <= go_i;
      port_latch_o <= port_latch_o + 8'h01;
    end
  end
endmodule // smsc_core_model

// ---- bench/smsc_stop_ctrl_monitor.sv ----
/* port assertions for the standby sequencer.
   assumes one clock clk_i and async active-high rst_i. */
`timescale 1ns/1ps
module smsc_chk #(parameter int PORT_W = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_instr_i,
  input wire logic int_pending_i,
  input wire logic ext_reset_i,
  input wire logic selectable_power_on_reset_reset_i,
  input wire logic cpu_clk_en_o,
  input wire logic hs_osc_en_o,
  input wire logic ls_osc_en_o,
  input wire logic wdt_run_o,
  input wire logic core_halt_o,
  input wire logic periph_clk_en_o,
  input wire logic reset_req_o,
  input wire logic resume_o,
  input wire logic [PORT_W-1:0] port_out_o
);
  // one domain, so one clocking and one disable
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_halt_gates_clk: assert property (core_halt_o |-> !cpu_clk_en_o)
    else $error("cpu clock live in halt");
  a_stop_osc_off: assert property (!hs_osc_en_o |-> core_halt_o && !periph_clk_en_o)
    else $error("stop without halt");
  a_stop_needs_instr: assert property ($fell(hs_osc_en_o) |-> $past(stop_instr_i, 3))
    else $error("stop without instruction");
  a_pend_no_stop: assert property (stop_instr_i && int_pending_i && !core_halt_o
    |=> core_halt_o && hs_osc_en_o)
    else $error("pending interrupt not honoured");
  a_port_hold: assert property (!hs_osc_en_o |-> $stable(port_out_o))
    else $error("port latch moved in stop");
  a_ls_for_wdt: assert property (!hs_osc_en_o && wdt_run_o |-> ls_osc_en_o)
    else $error("watchdog without slow clock");
  a_pin_reset: assert property ((ext_reset_i || selectable_power_on_reset_reset_i) [*4] |-> reset_req_o)
    else $error("pin reset not taken");
  a_resume_exit: assert property (resume_o |=> !core_halt_o && hs_osc_en_o)
    else $error("no run after resume");
endmodule // smsc_chk
bind smsc_stop_ctrl smsc_chk #(.PORT_W(PORT_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .stop_instr_i(stop_instr_i), .int_pending_i(int_pending_i), .ext_reset_i(ext_reset_i),
  .selectable_power_on_reset_reset_i(selectable_power_on_reset_reset_i), .cpu_clk_en_o(cpu_clk_en_o), .hs_osc_en_o(hs_osc_en_o),
  .ls_osc_en_o(ls_osc_en_o), .wdt_run_o(wdt_run_o), .core_halt_o(core_halt_o),
  .periph_clk_en_o(periph_clk_en_o), .reset_req_o(reset_req_o), .resume_o(resume_o),
  .port_out_o(port_out_o));

// ---- bench/tb_top.sv ----
/* bench for the standby sequencer: wishbone access, stop, wake, reset.
   assumes the core model drives the stop pulse and port latches. */
`timescale 1ns/1ps
module tb_top;
  localparam int REL = 100;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go_i = 0, idle_i = 0;
  logic int_pending_i = 0, int_ack_en_i = 0, ext_reset_i = 0, selectable_power_on_reset_reset_i = 0;
  logic ext_int_i = 0, key_int_i = 0, ack_o, stop_instr_i, cpu_clk_en_o, hs_osc_en_o;
  logic ls_osc_en_o, wdt_run_o, core_halt_o, flash_halt_o, ram_halt_o, periph_clk_en_o;
  logic wake_detect_en_o, reset_req_o, vector_int_o, resume_o;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic [7:0] port_latch_i, port_out_o, snap;
  int miscompares = 0, num_checks = 0, n;
  always #10 clk_i = ~clk_i;
  smsc_stop_ctrl #(.RELEASE_NS(REL)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .stop_instr_i(stop_instr_i), .idle_i(idle_i),
    .int_pending_i(int_pending_i), .int_ack_en_i(int_ack_en_i), .port_latch_i(port_latch_i),
    .ext_reset_i(ext_reset_i), .ext_int_i(ext_int_i), .key_int_i(key_int_i),
    .selectable_power_on_reset_reset_i(selectable_power_on_reset_reset_i), .cpu_clk_en_o(cpu_clk_en_o), .hs_osc_en_o(hs_osc_en_o),
    .ls_osc_en_o(ls_osc_en_o), .wdt_run_o(wdt_run_o), .core_halt_o(core_halt_o),
    .flash_halt_o(flash_halt_o), .ram_halt_o(ram_halt_o), .periph_clk_en_o(periph_clk_en_o),
    .wake_detect_en_o(wake_detect_en_o), .reset_req_o(reset_req_o),
    .vector_int_o(vector_int_o), .resume_o(resume_o), .port_out_o(port_out_o));
  smsc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_i),
    .stop_instr_o(stop_instr_i), .port_latch_o(port_latch_i));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, got);
    end
  endtask
  // classic cycle held until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  // one-cycle stop request through the core model
  task automatic go;
    go_i <= 1'b1;
    @(posedge clk_i);
    go_i <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(4'h4, 1'b0, 32'h0);
    chk("status", rdat, 32'h00000050);
    wb(4'hC, 1'b0, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("test regs done");
    for (int i = 0; i < 8; i++) begin
      wb(4'h0, 1'b1, {31'h0, i[2]});
      wb(4'h8, 1'b1, {27'h0, i[1], 3'h0, i[0]});
      wb(4'h8, 1'b0, 32'h0);
      chk("option", rdat, {27'h0, i[1], 3'h0, i[0]});
      wb(4'h0, 1'b0, 32'h0);
      chk("ctrl", rdat, {31'h0, i[2]});
      int_ack_en_i <= i[0];
      go;
      do @(posedge clk_i); while (hs_osc_en_o !== 1'b0);
      snap = port_out_o;
      chk("cpu clk", cpu_clk_en_o, 1'b0);
      chk("ls osc", ls_osc_en_o, i[2] | (i[1] & i[0]));
      chk("wdt", wdt_run_o, i[1] & i[0]);
      chk("flash halt", flash_halt_o, 1'b1);
      chk("ram halt", ram_halt_o, 1'b1);
      chk("periph clk", periph_clk_en_o, 1'b0);
      chk("wake det", wake_detect_en_o, 1'b1);
      // bus stays live in stop; this read also lets the held latch age
      wb(4'h4, 1'b0, 32'h0);
      chk("stop status", rdat, {25'h0, 1'b0, i[1] & i[0], i[2] | (i[1] & i[0]), 4'h2});
      chk("latch", port_out_o, snap);
      // wake by the core's pending flag, or by a synchronised pin source
      {key_int_i, ext_int_i, int_pending_i} <= i[2] ? {i[0], ~i[0], 1'b0} : 3'b001;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (resume_o !== 1'b1);
      chk("wake", n, REL / 20 + 1 + (i[2] ? 2 : 0) + (i[0] ? 11 : 3));
      chk("vector", vector_int_o, i[0]);
      {key_int_i, ext_int_i, int_pending_i} <= 3'h0;
      @(posedge clk_i);
      chk("run", cpu_clk_en_o, 1'b1);
      chk("flash run", flash_halt_o, 1'b0);
    end
    $display("test stop done");
    // interrupt already pending at the stop instruction
    int_pending_i <= 1'b1;
    go;
    n = 0;
    do begin
      @(posedge clk_i);
      n = n + (hs_osc_en_o !== 1'b1);
    end while (resume_o !== 1'b1);
    chk("osc kept", n, 0);
    int_pending_i <= 1'b0;
    $display("test pending done");
    // pin reset from idle, then from deep stop
    for (int j = 0; j < 2; j++) begin
      idle_i <= (j == 0);
      if (j == 1) go;
      repeat (6) @(posedge clk_i);
      chk("gated", cpu_clk_en_o, 1'b0);
      {selectable_power_on_reset_reset_i, ext_reset_i} <= j[0] ? 2'b10 : 2'b01;
      repeat (4) @(posedge clk_i);
      chk("reset req", reset_req_o, 1'b1);
      {selectable_power_on_reset_reset_i, ext_reset_i, idle_i} <= 3'h0;
      repeat (5) @(posedge clk_i);
      chk("back", cpu_clk_en_o, 1'b1);
    end
    $display("test reset done");
    complete_run;
  end
  // hang guard well past the expected run
  initial begin
    #400us;
    miscompares++;
    complete_run;
  end
endmodule // tb_top

// ---- core/smsc_consts.svh ----
/*
  constants for the standby sequencer: register offsets, field positions,
  reset values and timing counts.
  assumes a 50 MHz system clock and word-aligned wishbone addressing.
*/
`ifndef SMSC_CONSTS_SVH
`define SMSC_CONSTS_SVH

// register byte offsets
`define SMSC_REG_CTRL 4'h0
`define SMSC_REG_STATUS 4'h4
`define SMSC_REG_OPTION 4'h8

// ctrl fields
`define SMSC_CTRL_ITSEL_BIT 0
`define SMSC_CTRL_RESET 1'h0

// option byte fields
`define SMSC_OPT_STBYRUN_BIT 0
`define SMSC_OPT_WDTEN_BIT 4
`define SMSC_OPT_RESET 8'h00

// status fields
`define SMSC_ST_STATE_LSB 0
`define SMSC_ST_LSOSC_BIT 4
`define SMSC_ST_WDT_BIT 5
`define SMSC_ST_HSOSC_BIT 6

// timing: stop release time and clock period in ns, wait clocks after release and before stop
`define SMSC_RELEASE_NS 27000
`define SMSC_CLK_NS 20
`define SMSC_WAIT_VEC 11
`define SMSC_WAIT_NOVEC 3
`define SMSC_WAIT_STOP 2

`endif

// ---- core/smsc_pkg.sv ----
/*
  types for the standby sequencer.
  assumes smsc_consts.svh holds the numbers.
*/
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_RUN = 3'b000,
    SMSC_ENTER = 3'b001,
    SMSC_STOP = 3'b010,
    SMSC_STAB = 3'b011,
    SMSC_WAIT = 3'b100,
    SMSC_RESET = 3'b101
  } smsc_state_t;
endpackage

// ---- core/smsc_stop_ctrl.sv ----
/*
  deep-stop sequencer: takes the stop instruction, halts core, flash and
  ram, gates the cpu clock, stops the fast oscillator, freezes port latches,
  and releases on unmasked interrupt or reset.
  assumes core signals are on clk_i; wake and reset inputs come from pins.
*/
`timescale 1ns/1ps
`include "smsc_consts.svh"

module smsc_stop_ctrl #(
  parameter int PORT_W = 8,
  parameter int RELEASE_NS = `SMSC_RELEASE_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core side
  input wire logic stop_instr_i,
  input wire logic idle_i,
  input wire logic int_pending_i,
  input wire logic int_ack_en_i,
  input wire logic [PORT_W-1:0] port_latch_i,
  // wake sources from pins
  input wire logic ext_reset_i,
  input wire logic ext_int_i,
  input wire logic key_int_i,
  input wire logic selectable_power_on_reset_reset_i,
  // controls
  output logic cpu_clk_en_o,
  output logic hs_osc_en_o,
  output logic ls_osc_en_o,
  output logic wdt_run_o,
  output logic core_halt_o,
  output logic flash_halt_o,
  output logic ram_halt_o,
  output logic periph_clk_en_o,
  output logic wake_detect_en_o,
  output logic reset_req_o,
  output logic vector_int_o,
  output logic resume_o,
  output logic [PORT_W-1:0] port_out_o
);
  localparam int REL_CYC_RAW = (RELEASE_NS + `SMSC_CLK_NS - 1) / `SMSC_CLK_NS;
  localparam int REL_CYC = (REL_CYC_RAW < 1) ? 1 : REL_CYC_RAW;
  // counter must also hold the longer post-release wait for short release times
  localparam int CNT_MAX = (REL_CYC > `SMSC_WAIT_VEC) ? REL_CYC : `SMSC_WAIT_VEC;
  localparam int CW = $clog2(CNT_MAX + 1) + 1;
  // pin sources that pass the synchroniser
  localparam int NPIN = 4;

  smsc_pkg::smsc_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic vec, next_vec;
  logic [PORT_W-1:0] held, next_held;
  logic itsel, next_itsel;
  logic [7:0] option, next_option;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic [NPIN-1:0] pin_raw;
  wire logic [NPIN-1:0] pin_sync;
  logic wake_rst, wake_int;

  // pin sources gathered in one vector: bit 0 reset pin, 1 external
  // interrupt, 2 key interrupt, 3 power-on-reset detector
  assign pin_raw = {selectable_power_on_reset_reset_i, key_int_i, ext_int_i, ext_reset_i};

  // two-flop synchroniser per pin source; only the second stage is read,
  // so a metastable first stage never reaches the sequencer
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    logic stage_a, stage_b, next_stage_a, next_stage_b;
    always_comb begin
      next_stage_a = pin_raw[g];
      next_stage_b = stage_a;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        stage_a <= 1'b0;
        stage_b <= 1'b0;
      end else begin
        stage_a <= next_stage_a;
        stage_b <= next_stage_b;
      end
    end
    assign pin_sync[g] = stage_b;
  end

  // reset sources cost two cycles of latency; accepted, since a reset pin
  // is held far longer than that
  assign wake_rst = pin_sync[0] | pin_sync[3];
  // these detectors never see a gated clock, so they can wake from stop
  assign wake_int = int_pending_i | pin_sync[1] | pin_sync[2];

  function automatic logic [31:0] rd_mux(input logic [3:0] a, input logic [31:0] st,
                                         input logic ts, input logic [7:0] op);
    case (a)
      `SMSC_REG_CTRL: rd_mux = {31'h0, ts};
      `SMSC_REG_STATUS: rd_mux = st;
      `SMSC_REG_OPTION: rd_mux = {24'h0, op};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // last cycle of any timed state; shared by the sequencer and the resume pulse
  function automatic logic cnt_last(input logic [CW-1:0] c);
    cnt_last = (c <= CW'(1));
  endfunction

  logic [31:0] status;
  always_comb begin
    status = 32'h0;
    status[`SMSC_ST_STATE_LSB +: 3] = state;
    status[`SMSC_ST_LSOSC_BIT] = ls_osc_en_o;
    status[`SMSC_ST_WDT_BIT] = wdt_run_o;
    status[`SMSC_ST_HSOSC_BIT] = hs_osc_en_o;
  end

  // register file next values; ack one cycle after request, drops next cycle.
  // read data is latched when the request is taken and stands while ack is up
  always_comb begin
    next_ack = cyc_i & stb_i & ~ack;
    next_rdat = rdat;
    next_itsel = itsel;
    next_option = option;
    if (cyc_i && stb_i && !ack) begin
      next_rdat = rd_mux(adr_i, status, itsel, option);
    end
    // writes land on the edge where the master sees ack, never earlier,
    // so a request dropped before ack leaves the registers alone
    if (cyc_i && stb_i && ack && we_i && sel_i[0]) begin
      if (adr_i == `SMSC_REG_CTRL) begin
        next_itsel = dat_i[`SMSC_CTRL_ITSEL_BIT];
      end
      if (adr_i == `SMSC_REG_OPTION) begin
        next_option = dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h0;
      itsel <= `SMSC_CTRL_RESET;
      option <= `SMSC_OPT_RESET;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
      itsel <= next_itsel;
      option <= next_option;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdat;

  // sequencer: reset wins over interrupt release
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_vec = vec;
    next_held = held;
    case (state)
      smsc_pkg::SMSC_RUN: begin
        next_held = port_latch_i;
        if (wake_rst) begin
          next_state = smsc_pkg::SMSC_RESET;
        end else if (stop_instr_i) begin
          next_vec = int_ack_en_i;
          if (int_pending_i) begin
            next_state = smsc_pkg::SMSC_STAB;
            next_cnt = CW'(REL_CYC);
          end else begin
            next_state = smsc_pkg::SMSC_ENTER;
            next_cnt = CW'(`SMSC_WAIT_STOP);
          end
        end
      end
      smsc_pkg::SMSC_ENTER: begin
        // halts settle before clocks go away
        if (wake_rst) begin
          next_state = smsc_pkg::SMSC_RESET;
        end else if (cnt_last(cnt)) begin
          next_state = smsc_pkg::SMSC_STOP;
        end else begin
          next_cnt = cnt - CW'(1);
        end
      end
      smsc_pkg::SMSC_STOP: begin
        if (wake_rst) begin
          next_state = smsc_pkg::SMSC_RESET;
        end else if (wake_int) begin
          next_vec = int_ack_en_i;
          next_state = smsc_pkg::SMSC_STAB;
          next_cnt = CW'(REL_CYC);
        end
      end
      smsc_pkg::SMSC_STAB: begin
        if (wake_rst) begin
          next_state = smsc_pkg::SMSC_RESET;
        end else if (cnt_last(cnt)) begin
          // oscillator settled; wait length depends on the mode fixed at wake
          next_state = smsc_pkg::SMSC_WAIT;
          next_cnt = vec ? CW'(`SMSC_WAIT_VEC) : CW'(`SMSC_WAIT_NOVEC);
        end else begin
          next_cnt = cnt - CW'(1);
        end
      end
      smsc_pkg::SMSC_WAIT: begin
        if (wake_rst) begin
          next_state = smsc_pkg::SMSC_RESET;
        end else if (cnt_last(cnt)) begin
          next_state = smsc_pkg::SMSC_RUN;
        end else begin
          next_cnt = cnt - CW'(1);
        end
      end
      smsc_pkg::SMSC_RESET: begin
        // held while reset source stays asserted
        if (!wake_rst) begin
          next_state = smsc_pkg::SMSC_RUN;
        end
      end
      default: begin
        next_state = smsc_pkg::SMSC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= smsc_pkg::SMSC_RUN;
      cnt <= '0;
      vec <= 1'b0;
      held <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      vec <= next_vec;
      held <= next_held;
    end
  end

  logic in_stop, halted, osc_off;
  // stop is the only state with the fast oscillator down; every other
  // non-run state keeps it up so the release wait has a clock to count
  assign in_stop = (state == smsc_pkg::SMSC_STOP);
  assign osc_off = in_stop;
  assign halted = (state != smsc_pkg::SMSC_RUN);

  // clock and oscillator gating; the idle input is only followed, never forced
  always_comb begin
    cpu_clk_en_o = !halted && !idle_i;
    hs_osc_en_o = !osc_off;
    periph_clk_en_o = !in_stop;
  end

  // core, flash and ram halt from the first entry cycle, before the
  // oscillator stops, so none of them sees a clipped clock
  always_comb begin
    core_halt_o = halted;
    flash_halt_o = halted;
    ram_halt_o = halted;
  end

  // wake detection is never gated; software cannot turn it off
  assign wake_detect_en_o = 1'b1;

  // slow oscillator follows itsel and the option bits only while stopped; watchdog follows its enable bit always, the standby-run bit only in stop
  always_comb begin
    wdt_run_o = option[`SMSC_OPT_WDTEN_BIT] &&
                (!in_stop || option[`SMSC_OPT_STBYRUN_BIT]);
    ls_osc_en_o = !in_stop || itsel ||
                  (option[`SMSC_OPT_WDTEN_BIT] && option[`SMSC_OPT_STBYRUN_BIT]);
  end

  // handshake to the core: reset request, or a one-cycle resume pulse that ends the wait (reset returns to run without one);
  // a reset arriving in the last wait cycle suppresses the pulse
  always_comb begin
    reset_req_o = (state == smsc_pkg::SMSC_RESET);
    resume_o = (state == smsc_pkg::SMSC_WAIT) && cnt_last(cnt) && !wake_rst;
    vector_int_o = resume_o && vec;
  end

  // port pins come from the snapshot flop: it follows the live latch in run
  // and freezes on the first non-run cycle; costs one cycle of lag in run
  assign port_out_o = held;
endmodule // smsc_stop_ctrl
